// file: rtl/pdcs_regs.sv
// Device control and device status registers with Avalon-MM slave
//
// Summary of operation
// RULE1: Three error report enables, read-write, reset zero.
// RULE2: Unsupported request report enable, read-write, reset zero.
// RULE3: Relaxed ordering reads zero; never originated.
// RULE4: Payload field selects 128 to 2048 bytes.
// RULE5: Reserved payload codes behave as 128 bytes.
// RULE6: Wide tag bit limits debug tags.
// RULE7: Phantom function enable reads zero, read-only.
// RULE8: Aux power enable reads zero, read-only.
// RULE9: No snoop reads zero; never originated.
// RULE10: Read request size zero; originate 128 bytes max.
// RULE11: Correctable detected sticky, write-one clears.
// RULE12: Non-fatal detected sticky, write-one clears.
// RULE13: Fatal detected sticky, write-one clears.
// RULE14: Unsupported request detected sticky, write-one clears.
// RULE15: Aux power detected always reads zero.
// RULE16: Transactions pending always reads zero.
// RULE17: Payload capability defaults to 256 bytes.
// RULE18: Read-only, reserved writes ignored; zero writes keep.
// RULE19: Message emitted only when its enable set.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "pdcs_cfg.svh"

module pdcs_regs #(
	parameter logic [2:0] PAYLOAD_CAP = `PDCS_PAYLOAD_CAP_RST
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [`PDCS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Error detection events from the port logic
	input wire logic [`PDCS_NUM_ERR-1:0] errDetect,
	// Debug control from the transaction layer
	input wire logic sequentialTagDebug,
	// Error message requests towards the message generator
	output logic [`PDCS_NUM_ERR-1:0] errMsgSend,
	// Settings for the port logic
	output logic [`PDCS_NUM_ERR-1:0] reportEnable,
	output logic [11:0] maxPayloadBytes,
	output logic [7:0] maxTag,
	output logic origRelaxedOrdering,
	output logic origNoSnoop,
	output logic [11:0] origMaxReadBytes,
	// Interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [`PDCS_NUM_ERR-1:0] enables_q;
	logic [2:0] payloadSizeSel_q;
	logic wideTagEn_q;
	logic [`PDCS_NUM_ERR-1:0] detected_q;
	logic [`PDCS_NUM_ERR-1:0] irqStatus_q;
	logic [`PDCS_NUM_ERR-1:0] irqMask_q;
	logic ack_q;
	logic [31:0] readData_q;
	logic [11:0] payloadBytes_q;
	logic [7:0] maxTag_q;
	logic [`PDCS_NUM_ERR-1:0] errMsg_q;

	// Reset image of the sticky flags
	localparam logic [`PDCS_NUM_ERR-1:0] DETECT_RST = `PDCS_DETECT_RST;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic request;
	logic accept;
	logic wrStrobe;
	logic hitCtl;
	logic hitSts;
	logic hitIrqSts;
	logic hitIrqMsk;
	logic [15:0] wrData;
	logic [1:0] wrLane;
	logic [15:0] devControl;
	logic [15:0] devStatus;

	// Per-register write enables
	logic wrCtlLo;
	logic wrCtlHi;
	logic wrStsLo;
	logic wrIrqStsLo;
	logic wrIrqMskLo;

	// Read and payload decode
	logic [31:0] readMux;
	logic [11:0] selBytes;
	logic [11:0] capBytes;
	logic clipNeeded;

	// One wait state: data is prepared, then the request is accepted
	assign request = avs_read | avs_write;
	assign accept = request & ack_q;
	assign avs_waitrequest = request & ~ack_q;
	assign wrStrobe = avs_write & accept;

	// Address decode; each register sits on its own word
	assign hitCtl = avs_address == `PDCS_DEVCTL_ADDR;
	assign hitSts = avs_address == `PDCS_DEVSTS_ADDR;
	assign hitIrqSts = avs_address == `PDCS_IRQSTS_ADDR;
	assign hitIrqMsk = avs_address == `PDCS_IRQMSK_ADDR;

	// Only the low half-word carries register bits
	assign wrData = avs_writedata[15:0];
	assign wrLane = avs_byteenable[1:0];

	// Write enables per register and byte lane
	assign wrCtlLo = wrStrobe & hitCtl & wrLane[0];
	assign wrCtlHi = wrStrobe & hitCtl & wrLane[1];
	assign wrStsLo = wrStrobe & hitSts & wrLane[0];
	assign wrIrqStsLo = wrStrobe & hitIrqSts & wrLane[0];
	assign wrIrqMskLo = wrStrobe & hitIrqMsk & wrLane[0];

	// Acknowledge flag, high for the cycle that ends each request
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= request & ~ack_q;
		end
	end

	// ------------------------------------------------------------
	// Register images
	// ------------------------------------------------------------
	// Control image; hardwired fields and reserved bit read zero
	always_comb begin
		devControl = 16'h0000;
		devControl[`PDCS_CTL_CORR_BIT] =
			enables_q[pdcs_pkg::PDCS_ERR_CORR]; // RULE1
		devControl[`PDCS_CTL_NFAT_BIT] =
			enables_q[pdcs_pkg::PDCS_ERR_NFAT]; // RULE1
		devControl[`PDCS_CTL_FAT_BIT] =
			enables_q[pdcs_pkg::PDCS_ERR_FAT]; // RULE1
		devControl[`PDCS_CTL_UR_BIT] =
			enables_q[pdcs_pkg::PDCS_ERR_UR]; // RULE2
		devControl[`PDCS_CTL_RO_BIT] = 1'b0; // RULE3
		devControl[`PDCS_CTL_MPS_MSB:`PDCS_CTL_MPS_LSB] =
			payloadSizeSel_q; // RULE4
		devControl[`PDCS_CTL_TAG_BIT] = wideTagEn_q; // RULE6
		devControl[`PDCS_CTL_PF_BIT] = 1'b0; // RULE7
		devControl[`PDCS_CTL_AUX_BIT] = 1'b0; // RULE8
		devControl[`PDCS_CTL_NS_BIT] = 1'b0; // RULE9
		devControl[`PDCS_CTL_READ_REQUEST_SIZE_MSB:`PDCS_CTL_READ_REQUEST_SIZE_LSB] = 3'h0; // RULE10
	end

	// Status image; aux power and pending bits are hardwired
	always_comb begin
		devStatus = 16'h0000;
		devStatus[`PDCS_NUM_ERR-1:0] = detected_q;
		devStatus[`PDCS_STS_AUX_POWER_DETECTED_BIT] = 1'b0; // RULE15
		devStatus[`PDCS_STS_TP_BIT] = 1'b0; // RULE16
	end

	// ------------------------------------------------------------
	// Control register writes
	// ------------------------------------------------------------
	// Report enables in the low byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enables_q <= `PDCS_ENABLES_RST; // RULE1
		end else if (wrCtlLo) begin
			enables_q <= wrData[`PDCS_NUM_ERR-1:0]; // RULE2
		end
	end

	// Payload size select, straddles byte zero only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			payloadSizeSel_q <= `PDCS_MPS_RST; // RULE4
		end else if (wrCtlLo) begin
			payloadSizeSel_q <=
				wrData[`PDCS_CTL_MPS_MSB:`PDCS_CTL_MPS_LSB];
		end
	end

	// Wide tag enable in byte one; other byte-one bits are dropped
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wideTagEn_q <= `PDCS_TAG_RST;
		end else if (wrCtlHi) begin
			wideTagEn_q <= wrData[`PDCS_CTL_TAG_BIT]; // RULE18
		end
	end

	// ------------------------------------------------------------
	// Error detected flags and interrupt status
	// ------------------------------------------------------------
	// One sticky flag pair per error class; a new event wins over
	// a clear in the same cycle, and a zero written leaves a flag
	genvar gi;
	generate
		for (gi = 0; gi < `PDCS_NUM_ERR; gi++) begin : g_err
			logic clrDet;
			logic clrIrq;
			assign clrDet = wrStsLo & wrData[gi];
			assign clrIrq = wrIrqStsLo & wrData[gi];

			// Detected flag, set regardless of the enable
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					detected_q[gi] <= DETECT_RST[gi];
				end else if (errDetect[gi]) begin
					detected_q[gi] <= 1'b1; // RULE11 RULE12 RULE13 RULE14
				end else if (clrDet) begin
					detected_q[gi] <= 1'b0; // RULE18
				end
			end

			// Interrupt status flag for the same event
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					irqStatus_q[gi] <= DETECT_RST[gi];
				end else if (errDetect[gi]) begin
					irqStatus_q[gi] <= 1'b1;
				end else if (clrIrq) begin
					irqStatus_q[gi] <= 1'b0;
				end
			end

			// Message request only when reporting is enabled
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					errMsg_q[gi] <= 1'b0;
				end else begin
					errMsg_q[gi] <= errDetect[gi] & enables_q[gi]; // RULE19
				end
			end
		end
	endgenerate

	// Interrupt mask, same layout as the interrupt status
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irqMask_q <= `PDCS_IRQMSK_RST;
		end else if (wrIrqMskLo) begin
			irqMask_q <= wrData[`PDCS_NUM_ERR-1:0];
		end
	end

	// Level interrupt while an unmasked status bit is set
	assign irq = |(irqStatus_q & irqMask_q);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Image picked by the address; unmapped reads give zero
	always_comb begin
		readMux = 32'h00000000;
		if (hitCtl) begin
			readMux = {16'h0000, devControl};
		end else if (hitSts) begin
			readMux = {16'h0000, devStatus};
		end else if (hitIrqSts) begin
			readMux = {28'h0000000, irqStatus_q};
		end else if (hitIrqMsk) begin
			readMux = {28'h0000000, irqMask_q};
		end
	end

	// Read data captured in the wait cycle, held until the next read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			readData_q <= `PDCS_READDATA_RST;
		end else if (avs_read && !ack_q) begin
			readData_q <= readMux;
		end
	end

	// Read data leaves straight from the flip-flops
	assign avs_readdata = readData_q;

	// ------------------------------------------------------------
	// Settings for the port logic
	// ------------------------------------------------------------
	// Bytes for the selected code; reserved codes mean 128 bytes
	always_comb begin
		unique case (payloadSizeSel_q)
			pdcs_pkg::PDCS_S128: selBytes = 12'h080; // RULE4
			pdcs_pkg::PDCS_S256: selBytes = 12'h100;
			pdcs_pkg::PDCS_S512: selBytes = 12'h200;
			pdcs_pkg::PDCS_S1024: selBytes = 12'h400;
			pdcs_pkg::PDCS_S2048: selBytes = 12'h800;
			default: selBytes = 12'h080; // RULE5
		endcase
	end

	// Largest payload the port advertises
	assign capBytes = 12'(12'h080 << PAYLOAD_CAP); // RULE17

	// Legal codes above the capability are clipped to it
	assign clipNeeded = payloadSizeSel_q <= 3'h4 &&
		payloadSizeSel_q > PAYLOAD_CAP && PAYLOAD_CAP <= 3'h4;

	// Effective payload, registered for the port logic
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			payloadBytes_q <= `PDCS_PAYLOAD_BYTES_RST;
		end else if (clipNeeded) begin
			payloadBytes_q <= capBytes; // RULE17
		end else begin
			payloadBytes_q <= selBytes; // RULE4 RULE5
		end
	end

	// Tag range; the enable matters only in sequential tag debug
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			maxTag_q <= `PDCS_WIDE_TAG_MAX;
		end else if (sequentialTagDebug && !wideTagEn_q) begin
			maxTag_q <= `PDCS_NARROW_TAG_MAX; // RULE6
		end else begin
			maxTag_q <= `PDCS_WIDE_TAG_MAX;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Settings taken from the registers
	assign reportEnable = enables_q;
	assign maxPayloadBytes = payloadBytes_q;
	assign maxTag = maxTag_q;
	assign errMsgSend = errMsg_q;

	// Attributes the bridge never originates, and its originated read size limit
	assign origRelaxedOrdering = 1'b0; // RULE3
	assign origNoSnoop = 1'b0; // RULE9
	assign origMaxReadBytes = `PDCS_ORIG_READ_MAX; // RULE10

endmodule : pdcs_regs

// file: rtl/pdcs_cfg.svh
// Register offsets, field positions, reset values and constants
`ifndef PDCS_CFG_SVH
`define PDCS_CFG_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define PDCS_DEVCTL_IDX 10'h048
`define PDCS_DEVSTS_IDX 10'h04a
`define PDCS_IRQSTS_IDX 10'h050
`define PDCS_IRQMSK_IDX 10'h051
`define PDCS_ADDR_W 12
`define PDCS_DEVCTL_ADDR 12'h120
`define PDCS_DEVSTS_ADDR 12'h128
`define PDCS_IRQSTS_ADDR 12'h140
`define PDCS_IRQMSK_ADDR 12'h144

// ----------------------------------------------------------------
// Device control fields
// ----------------------------------------------------------------
`define PDCS_CTL_CORR_BIT 0
`define PDCS_CTL_NFAT_BIT 1
`define PDCS_CTL_FAT_BIT 2
`define PDCS_CTL_UR_BIT 3
`define PDCS_CTL_RO_BIT 4
`define PDCS_CTL_MPS_LSB 5
`define PDCS_CTL_MPS_MSB 7
`define PDCS_CTL_TAG_BIT 8
`define PDCS_CTL_PF_BIT 9
`define PDCS_CTL_AUX_BIT 10
`define PDCS_CTL_NS_BIT 11
`define PDCS_CTL_READ_REQUEST_SIZE_LSB 12
`define PDCS_CTL_READ_REQUEST_SIZE_MSB 14

// ----------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------
`define PDCS_NUM_ERR 4
`define PDCS_STS_AUX_POWER_DETECTED_BIT 4
`define PDCS_STS_TP_BIT 5
`define PDCS_ENABLES_RST 4'h0
`define PDCS_MPS_RST 3'h0
`define PDCS_TAG_RST 1'h0
`define PDCS_DETECT_RST 4'h0
`define PDCS_IRQMSK_RST 4'h0
`define PDCS_PAYLOAD_CAP_RST 3'h1
`define PDCS_PAYLOAD_BYTES_RST 12'h080
`define PDCS_READDATA_RST 32'h00000000
`define PDCS_NARROW_TAG_MAX 8'h1f
`define PDCS_WIDE_TAG_MAX 8'hff
`define PDCS_ORIG_READ_MAX 12'h080

`endif

// file: rtl/pdcs_pkg.sv
// Types shared by the device control and status register block
package pdcs_pkg;

	// Maximum payload size codes
	typedef enum logic [2:0] {
		PDCS_S128 = 3'h0,
		PDCS_S256 = 3'h1,
		PDCS_S512 = 3'h2,
		PDCS_S1024 = 3'h3,
		PDCS_S2048 = 3'h4
	} pdcs_payload_t;

	// Error classes, one status and enable bit each
	typedef enum logic [1:0] {
		PDCS_ERR_CORR = 2'h0,
		PDCS_ERR_NFAT = 2'h1,
		PDCS_ERR_FAT = 2'h2,
		PDCS_ERR_UR = 2'h3
	} pdcs_err_t;

endpackage : pdcs_pkg

// file: verification/pdcs_regs_assertions.sv
// Assertion checker for the device control and status block
`timescale 1ns/1ps
`include "pdcs_cfg.svh"

module pdcs_regs_assertions #(
	parameter logic [2:0] PAYLOAD_CAP = 3'h1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register bus
	input wire logic [`PDCS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Port side
	input wire logic [`PDCS_NUM_ERR-1:0] errDetect,
	input wire logic sequentialTagDebug,
	input wire logic [`PDCS_NUM_ERR-1:0] errMsgSend,
	input wire logic [`PDCS_NUM_ERR-1:0] reportEnable,
	input wire logic [11:0] maxPayloadBytes,
	input wire logic [7:0] maxTag,
	input wire logic origRelaxedOrdering,
	input wire logic origNoSnoop,
	input wire logic [11:0] origMaxReadBytes,
	input wire logic irq
);
	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Request still inside its wait state
	sequence s_waiting;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// Read of the status register being completed
	sequence s_status_read;
		avs_read && !avs_waitrequest && avs_address == `PDCS_DEVSTS_ADDR;
	endsequence

	a_one_wait: assert property (s_waiting |=> !avs_waitrequest)
		else $error("request not answered after one wait state");
	a_msg_gated: assert property (
		errMsgSend == $past(errDetect & reportEnable))
		else $error("message does not follow enabled event");
	a_no_relaxed: assert property (!origRelaxedOrdering)
		else $error("relaxed ordering originated");
	a_no_snoop: assert property (!origNoSnoop)
		else $error("no snoop originated");
	a_read_limit: assert property (origMaxReadBytes == 12'h080)
		else $error("originated read size not 128 bytes");
	a_payload_ok: assert property (
		maxPayloadBytes inside {12'h080, 12'h100, 12'h200, 12'h400,
		12'h800} && maxPayloadBytes <= (12'h080 << PAYLOAD_CAP))
		else $error("payload size outside legal set");
	a_tag_mode: assert property (
		(maxTag == 8'hff || maxTag == 8'h1f && $past(sequentialTagDebug)))
		else $error("tag limit wrong for mode");
	a_status_zero: assert property (
		s_status_read |-> avs_readdata[15:4] == 12'h000)
		else $error("fixed status bits not zero");
	a_irq_cause: assert property (
		$rose(irq) |-> $past(|errDetect) || $past(avs_write))
		else $error("interrupt rose without cause");
endmodule : pdcs_regs_assertions

bind pdcs_regs pdcs_regs_assertions #(.PAYLOAD_CAP(PAYLOAD_CAP))
	i_pdcs_regs_assertions (.clk(clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .errDetect(errDetect),
	.sequentialTagDebug(sequentialTagDebug), .errMsgSend(errMsgSend),
	.reportEnable(reportEnable), .maxPayloadBytes(maxPayloadBytes),
	.maxTag(maxTag), .origRelaxedOrdering(origRelaxedOrdering),
	.origNoSnoop(origNoSnoop), .origMaxReadBytes(origMaxReadBytes),
	.irq(irq));

// file: verification/pdcs_port_model.sv
// Model of the port logic that raises error events and takes messages
`timescale 1ns/1ps
`include "pdcs_cfg.svh"

module pdcs_port_model (
	// Clock
	input wire logic clk,
	// Events out, messages in
	output logic [`PDCS_NUM_ERR-1:0] errDetect,
	input wire logic [`PDCS_NUM_ERR-1:0] errMsgSend
);
	// Messages seen per error class
	int msgCount [`PDCS_NUM_ERR] = '{default: 0};

	initial errDetect = '0;

	// Count every one-cycle message request
	always @(posedge clk) begin
		foreach (msgCount[i]) if (errMsgSend[i] === 1'b1) msgCount[i]++;
	end

	// One-cycle detection pulse launched just after an edge
	task automatic pulse(input int cls);
		@(posedge clk);
		errDetect[cls] <= 1'b1;
		@(posedge clk);
		errDetect[cls] <= 1'b0;
	endtask : pulse
endmodule : pdcs_port_model

// file: verification/pdcs_regs_tb.sv
// Self-checking bench for the device control and status block
`timescale 1ns/1ps
`include "pdcs_cfg.svh"

module pdcs_regs_tb;
	// ------------------------------------------------
	// Signals and instances
	// ------------------------------------------------
	localparam logic [11:0] CTL = `PDCS_DEVCTL_ADDR;
	localparam logic [11:0] STS = `PDCS_DEVSTS_ADDR;
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic [11:0] addr = '0;
	logic rd = 1'b0, wr = 1'b0, tagDbg = 1'b0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata, got;
	logic waitReq, irq, roOut, nsOut;
	logic [3:0] errDetect, msgSend, repEn;
	logic [3:0] be = 4'h3;
	logic [11:0] payload, readMax;
	logic [7:0] maxTag;
	int nErrors = 0, checked = 0;

	// Clock at 25 MHz
	always #20 clk = ~clk;

	pdcs_regs #(.PAYLOAD_CAP(3'h4)) i_pdcs_regs (.clk(clk),
		.sys_rst(sysRst), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_byteenable(be), .avs_writedata(wdata),
		.avs_readdata(rdata), .avs_waitrequest(waitReq),
		.errDetect(errDetect), .sequentialTagDebug(tagDbg),
		.errMsgSend(msgSend), .reportEnable(repEn),
		.maxPayloadBytes(payload), .maxTag(maxTag),
		.origRelaxedOrdering(roOut), .origNoSnoop(nsOut),
		.origMaxReadBytes(readMax), .irq(irq));
	pdcs_port_model i_pdcs_port_model (.clk(clk),
		.errDetect(errDetect), .errMsgSend(msgSend));

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			nErrors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic reportAndStop();
		if (nErrors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : reportAndStop

	// One bus cycle held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [15:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {16'h0000, d};
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (!waitReq) break;
		end
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n == 16) begin
			nErrors++;
			reportAndStop();
		end
	endtask : bus

	// Write then read back and compare
	task automatic wrChk(input logic [11:0] a, input logic [15:0] d,
		input logic [31:0] exp);
		bus(1'b1, a, d);
		bus(1'b0, a, 16'h0000);
		check(got, exp);
	endtask : wrChk

	// ------------------------------------------------
	// Sequence
	// ------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		sysRst <= 1'b0;
		bus(1'b0, CTL, 16'h0000);
		check(got, 32'h0);
		bus(1'b0, STS, 16'h0000);
		check(got, 32'h0);
		check({payload, maxTag, irq}, {12'h080, 8'hff, 1'b0});
		wrChk(CTL, 16'hffff, 32'h01ef);
		check({repEn, roOut, nsOut, readMax}, 18'h3c080);
		// Every payload code, reserved ones included
		for (int c = 0; c < 8; c++) begin
			wrChk(CTL, 16'(c << 5), 32'(c << 5));
			repeat (2) @(posedge clk);
			check(payload, c > 4 ? 12'h080 : 12'h080 << c);
		end
		// Tag range only narrows in debug mode
		tagDbg <= 1'b1;
		wrChk(CTL, 16'h0000, 32'h0);
		repeat (2) @(posedge clk);
		check(maxTag, 8'h1f);
		wrChk(CTL, 16'h0100, 32'h0100);
		repeat (2) @(posedge clk);
		check(maxTag, 8'hff);
		// Lane one alone writes only the wide tag bit
		be <= 4'h2;
		wrChk(CTL, 16'h00ff, 32'h0000);
		repeat (2) @(posedge clk);
		check(maxTag, 8'h1f);
		// Events with only two classes enabled, lane zero alone
		be <= 4'h1;
		wrChk(CTL, 16'hff05, 32'h0005);
		be <= 4'h3;
		for (int i = 0; i < 4; i++) begin
			i_pdcs_port_model.pulse(i);
			repeat (2) @(posedge clk);
			check(i_pdcs_port_model.msgCount[i], 32'(i % 2 == 0));
		end
		bus(1'b0, STS, 16'h0000);
		check(got, 32'h000f);
		wrChk(STS, 16'hfff0, 32'h000f);
		wrChk(STS, 16'h0005, 32'h000a);
		wrChk(STS, 16'h000a, 32'h0);
		// Interrupt masked, unmasked, cleared
		check(irq, 1'b0);
		wrChk(`PDCS_IRQMSK_ADDR, 16'h0002, 32'h0002);
		check(irq, 1'b1);
		wrChk(`PDCS_IRQSTS_ADDR, 16'h000f, 32'h0);
		check(irq, 1'b0);
		wrChk(12'h7f0, 16'hffff, 32'h0);
		reportAndStop();
	end
endmodule : pdcs_regs_tb
